// file: lfc_pkg.sv
// Purpose: shared constants and types for the low-side fault capture block
// Assumes: core clock of 20 MHz, six channels
// Notes: status codes and timer figures are set here only
package lfc_pkg;
    localparam int CH = 6;
    localparam int CLK_HZ = 20_000_000;

    // timer figures in microseconds, then whole cycles rounded up
    localparam int TURN_OFF_BLANK_TIME_US = 100;
    localparam int TURN_ON_BLANK_TIME_US = 50;
    localparam int FILTER_TIME_US = 20;
    localparam int TURN_OFF_BLANK_CYC = (TURN_OFF_BLANK_TIME_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int TURN_ON_BLANK_CYC = (TURN_ON_BLANK_TIME_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int FILTER_CYC = (FILTER_TIME_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int CNT_W = 12;

    // diag_config_two field positions: open-load enables low, fast-charge enables high
    localparam int OPEN_LOAD_DIAG_ENABLE_LSB = 0;
    localparam int FAST_CHARGE_ENABLE_LSB = 6;
    localparam logic [11:0] DIAG_CONFIG_TWO_RESET = 12'h03f;

    // drain comparison classes
    typedef enum logic [1:0] {
        LFC_CMP_OK = 2'h0,
        LFC_CMP_SHORTED_LOAD = 2'h1,
        LFC_CMP_GROUND_SHORT = 2'h2,
        LFC_CMP_OPEN_LOAD = 2'h3
    } lfc_cmp_t;

    // three-bit status codes per channel
    typedef enum logic [2:0] {
        LFC_ST_COMPLETE_OK = 3'h0,
        LFC_ST_SHORTED_LOAD = 3'h1,
        LFC_ST_GROUND_SHORT = 3'h2,
        LFC_ST_OPEN_LOAD = 3'h3,
        LFC_ST_NO_SHORTED_LOAD = 3'h4,
        LFC_ST_NO_OFF_FAULT = 3'h5,
        LFC_ST_NOT_COMPLETE = 3'h7
    } lfc_status_t;

    // analog comparator outputs for one channel
    typedef struct packed {
        logic aboveShortRef;
        logic aboveOpenLoadRef;
        logic belowGroundShortRef;
        logic atBridgeCenter;
    } lfc_cmp_pins_t;
endpackage

// file: lfc_lowside_fault_capture.sv
// Purpose: fault detection, capture and fault flag for six low-side channels
// Assumes: comparator and pin inputs are asynchronous; serial gate command,
//          frame valid and clear mask come from serial logic on core_clk
// Notes:
`timescale 1ns/1ns
module lfc_lowside_fault_capture #(
    parameter int CH = lfc_pkg::CH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic masterResetN,
    input wire logic masterDisable,
    input wire logic serialSelectN,
    input wire logic [CH-1:0] parallelChannelInput,
    input wire logic [CH-1:0] serialGateCommand,
    input wire lfc_pkg::lfc_cmp_pins_t [CH-1:0] drainFeedback,
    input wire logic [11:0] diagConfigTwo,
    input wire logic frameValid,
    input wire logic [CH-1:0] statusClearMask,
    output logic faultFlagN,
    output logic faultFlagOe,
    output logic [CH-1:0] fastChargeCurrent,
    output lfc_pkg::lfc_status_t [CH-1:0] channelStatus
);
    localparam logic [lfc_pkg::CNT_W-1:0] OFF_CNT = lfc_pkg::CNT_W'(lfc_pkg::TURN_OFF_BLANK_CYC);
    localparam logic [lfc_pkg::CNT_W-1:0] ON_CNT = lfc_pkg::CNT_W'(lfc_pkg::TURN_ON_BLANK_CYC);
    localparam logic [lfc_pkg::CNT_W-1:0] FLT_CNT = lfc_pkg::CNT_W'(lfc_pkg::FILTER_CYC);
    localparam logic [lfc_pkg::CNT_W-1:0] CNT_ONE = lfc_pkg::CNT_W'(1);

    typedef struct packed {
        logic rstS1;
        logic rstS2;
        logic disS1;
        logic disS2;
        logic selS1;
        logic selS2;
        logic selPrev;
        logic diagOnPrev;
        logic [CH-1:0] inS1;
        logic [CH-1:0] inS2;
        lfc_pkg::lfc_cmp_pins_t [CH-1:0] fbS1;
        lfc_pkg::lfc_cmp_pins_t [CH-1:0] fbS2;
        logic [CH-1:0] cmdPrev;
        lfc_pkg::lfc_cmp_t [CH-1:0] cmpPrev;
        logic [CH-1:0] blankOn;
        logic [CH-1:0][lfc_pkg::CNT_W-1:0] blankCnt;
        logic [CH-1:0] filtOn;
        logic [CH-1:0][lfc_pkg::CNT_W-1:0] filtCnt;
        logic [CH-1:0] charge;
        lfc_pkg::lfc_status_t [CH-1:0] status;
        logic flagOe;
        logic flagLevel;
    } lfc_state_t;

    lfc_state_t s_q;
    lfc_state_t s_d;

    logic diagOn;
    logic diagRise;
    logic clearEvent;
    logic anyFault;
    logic [CH-1:0] cmd;
    logic [CH-1:0] blankStart;
    logic [CH-1:0] blankEnd;
    logic [CH-1:0] filtStart;
    logic [CH-1:0] filtEnd;
    logic [CH-1:0] latchNow;
    logic [CH-1:0] chanFault;
    lfc_pkg::lfc_cmp_t [CH-1:0] cmpNow;

    // severity order used for promotion; higher wins
    function automatic logic [2:0] rank(input lfc_pkg::lfc_status_t st);
        case (st)
            lfc_pkg::LFC_ST_SHORTED_LOAD: rank = 3'h5;
            lfc_pkg::LFC_ST_GROUND_SHORT: rank = 3'h4;
            lfc_pkg::LFC_ST_OPEN_LOAD: rank = 3'h3;
            lfc_pkg::LFC_ST_COMPLETE_OK: rank = 3'h2;
            lfc_pkg::LFC_ST_NO_SHORTED_LOAD: rank = 3'h1;
            lfc_pkg::LFC_ST_NO_OFF_FAULT: rank = 3'h1;
            default: rank = 3'h0;
        endcase
    endfunction

    // sort the drain comparators into one class for the commanded state
    function automatic lfc_pkg::lfc_cmp_t classify(input logic on, input lfc_pkg::lfc_cmp_pins_t fb,
                                                   input logic olEn);
        if (on)
            classify = fb.aboveShortRef ? lfc_pkg::LFC_CMP_SHORTED_LOAD : lfc_pkg::LFC_CMP_OK;
        else if (fb.belowGroundShortRef)
            classify = lfc_pkg::LFC_CMP_GROUND_SHORT;
        else if (!fb.aboveOpenLoadRef && olEn)
            classify = lfc_pkg::LFC_CMP_OPEN_LOAD;
        else
            classify = lfc_pkg::LFC_CMP_OK;
    endfunction

    // status that a completed comparison proposes, before the promotion check
    function automatic lfc_pkg::lfc_status_t propose(input lfc_pkg::lfc_status_t old, input logic on,
                                                     input lfc_pkg::lfc_cmp_t c);
        case (c)
            lfc_pkg::LFC_CMP_SHORTED_LOAD: propose = lfc_pkg::LFC_ST_SHORTED_LOAD;
            lfc_pkg::LFC_CMP_GROUND_SHORT: propose = lfc_pkg::LFC_ST_GROUND_SHORT;
            lfc_pkg::LFC_CMP_OPEN_LOAD: propose = lfc_pkg::LFC_ST_OPEN_LOAD;
            default:
                if (on)
                    propose = (old == lfc_pkg::LFC_ST_NO_OFF_FAULT) ? lfc_pkg::LFC_ST_COMPLETE_OK
                                                                    : lfc_pkg::LFC_ST_NO_SHORTED_LOAD;
                else
                    propose = (old == lfc_pkg::LFC_ST_NO_SHORTED_LOAD) ? lfc_pkg::LFC_ST_COMPLETE_OK
                                                                       : lfc_pkg::LFC_ST_NO_OFF_FAULT;
        endcase
    endfunction

    // diagnostics live only with reset released and disable low
    assign diagOn = s_q.rstS2 & ~s_q.disS2;
    assign diagRise = diagOn & ~s_q.diagOnPrev;
    assign clearEvent = s_q.selS2 & ~s_q.selPrev & frameValid;
    assign anyFault = |chanFault;

    // per-channel trigger and expiry terms
    genvar g;
    generate
        for (g = 0; g < CH; g++)
        begin : g_chan
            assign cmd[g] = s_q.inS2[g] | serialGateCommand[g];
            assign cmpNow[g] = classify(cmd[g], s_q.fbS2[g],
                                        diagConfigTwo[lfc_pkg::OPEN_LOAD_DIAG_ENABLE_LSB + g]);
            assign blankStart[g] = diagRise | (diagOn & (cmd[g] != s_q.cmdPrev[g]));
            assign filtStart[g] = diagOn & (cmpNow[g] != s_q.cmpPrev[g]);
            assign blankEnd[g] = s_q.blankOn[g] & (s_q.blankCnt[g] == CNT_ONE);
            assign filtEnd[g] = s_q.filtOn[g] & (s_q.filtCnt[g] == CNT_ONE);
            // a timer still running holds the latch off, so a filter still running at the blank end extends the blank
            assign latchNow[g] = diagOn & (blankEnd[g] | filtEnd[g])
                               & ~(s_q.blankOn[g] & ~blankEnd[g])
                               & ~(s_q.filtOn[g] & ~filtEnd[g]);
            assign chanFault[g] = (s_q.status[g] == lfc_pkg::LFC_ST_SHORTED_LOAD)
                                | (s_q.status[g] == lfc_pkg::LFC_ST_GROUND_SHORT)
                                | (s_q.status[g] == lfc_pkg::LFC_ST_OPEN_LOAD);
        end
    endgenerate

    // next state; the clear is applied before a same-cycle latch so a new fault is kept
    always_comb
    begin
        s_d = s_q;
        s_d.rstS1 = masterResetN;
        s_d.rstS2 = s_q.rstS1;
        s_d.disS1 = masterDisable;
        s_d.disS2 = s_q.disS1;
        s_d.selS1 = serialSelectN;
        s_d.selS2 = s_q.selS1;
        s_d.selPrev = s_q.selS2;
        s_d.inS1 = parallelChannelInput;
        s_d.inS2 = s_q.inS1;
        s_d.fbS1 = drainFeedback;
        s_d.fbS2 = s_q.fbS1;
        s_d.diagOnPrev = diagOn;
        s_d.cmdPrev = cmd;
        s_d.cmpPrev = cmpNow;
        for (int i = 0; i < CH; i++)
        begin
            // blanking timer: reload on any trigger, count down otherwise
            if (!diagOn)
                s_d.blankOn[i] = 1'b0;
            else if (blankStart[i])
            begin
                s_d.blankOn[i] = 1'b1;
                s_d.blankCnt[i] = cmd[i] ? ON_CNT : OFF_CNT;
            end
            else if (s_q.blankOn[i])
            begin
                s_d.blankOn[i] = !blankEnd[i];
                s_d.blankCnt[i] = s_q.blankCnt[i] - CNT_ONE;
            end
            // filter timer restarts on every comparison change, so a glitch latches only when it lands on a timer's last cycle
            if (!diagOn)
                s_d.filtOn[i] = 1'b0;
            else if (filtStart[i])
            begin
                s_d.filtOn[i] = 1'b1;
                s_d.filtCnt[i] = FLT_CNT;
            end
            else if (s_q.filtOn[i])
            begin
                s_d.filtOn[i] = !filtEnd[i];
                s_d.filtCnt[i] = s_q.filtCnt[i] - CNT_ONE;
            end
            // fast charge only helps a turn-off transient, so it never outlives the blank
            if (!diagOn)
                s_d.charge[i] = 1'b0;
            else if (blankStart[i] & ~cmd[i])
                s_d.charge[i] = diagConfigTwo[lfc_pkg::FAST_CHARGE_ENABLE_LSB + i];
            else if (s_q.fbS2[i].atBridgeCenter | blankEnd[i] | cmd[i])
                s_d.charge[i] = 1'b0;
            // status: reset, frame clear, then promotion-only latch
            if (!s_q.rstS2)
                s_d.status[i] = lfc_pkg::LFC_ST_NOT_COMPLETE;
            else
            begin
                if (clearEvent & statusClearMask[i])
                    s_d.status[i] = lfc_pkg::LFC_ST_NOT_COMPLETE;
                if (latchNow[i]
                    && rank(propose(s_d.status[i], cmd[i], cmpNow[i])) > rank(s_d.status[i]))
                    s_d.status[i] = propose(s_d.status[i], cmd[i], cmpNow[i]);
            end
        end
        // flag pulls low only while enabled and deselected (select line high); otherwise released
        s_d.flagOe = diagOn & s_q.selS2 & anyFault;
        s_d.flagLevel = 1'b0;
    end

    // single state register; power-on leaves everything released and not complete
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
            for (int i = 0; i < CH; i++)
                s_q.status[i] <= lfc_pkg::LFC_ST_NOT_COMPLETE;
        end
        else
            s_q <= s_d;
    end

    assign faultFlagN = s_q.flagLevel;
    assign faultFlagOe = s_q.flagOe;
    assign fastChargeCurrent = s_q.charge;
    assign channelStatus = s_q.status;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // enable edge followed by every channel blanking
    sequence s_enableEdge;
        s_q.rstS2 && !s_q.disS2 && !s_q.diagOnPrev;
    endsequence
    sequence s_allBlanking;
        s_q.blankOn == {CH{1'b1}};
    endsequence
    sequence s_blankRunning;
        s_q.blankOn[0] && !blankEnd[0];
    endsequence

    property p_flagNeedsEnable;
        faultFlagOe |-> $past(s_q.rstS2 && !s_q.disS2 && s_q.selS2 && anyFault);
    endproperty
    a_flagNeedsEnable: assert property (p_flagNeedsEnable) else $error("flag driven while not enabled");

    property p_flagReleased;
        (!s_q.selS2 || !s_q.rstS2 || s_q.disS2) |=> !faultFlagOe;
    endproperty
    a_flagReleased: assert property (p_flagReleased) else $error("flag not released");

    property p_flagOnFault;
        (diagOn && s_q.selS2 && anyFault) |=> faultFlagOe;
    endproperty
    a_flagOnFault: assert property (p_flagOnFault) else $error("fault not flagged");

    property p_resetClearsStatus;
        !s_q.rstS2 |=> channelStatus[0] == lfc_pkg::LFC_ST_NOT_COMPLETE;
    endproperty
    a_resetClearsStatus: assert property (p_resetClearsStatus) else $error("status kept in reset");

    property p_noDemote;
        (s_q.rstS2 && !(clearEvent && statusClearMask[0])) |=> rank(channelStatus[0]) >= rank($past(channelStatus[0]));
    endproperty
    a_noDemote: assert property (p_noDemote) else $error("status demoted");

    property p_latchOnlyAtTimer;
        (s_q.rstS2 && !latchNow[0] && !(clearEvent && statusClearMask[0])) |=> $stable(channelStatus[0]);
    endproperty
    a_latchOnlyAtTimer: assert property (p_latchOnlyAtTimer) else $error("status moved without timer");

    property p_allBlankOnEnable;
        s_enableEdge |=> s_allBlanking;
    endproperty
    a_allBlankOnEnable: assert property (p_allBlankOnEnable) else $error("blanking not started");

    property p_blankOnInput;
        (diagOn && cmd[0] != s_q.cmdPrev[0]) |=> s_q.blankOn[0] ##1 s_q.blankOn[0];
    endproperty
    a_blankOnInput: assert property (p_blankOnInput) else $error("input change did not blank");

    property p_chargeInsideBlank;
        (fastChargeCurrent & ~(s_q.blankOn & ~s_q.cmdPrev)) == '0;
    endproperty
    a_chargeInsideBlank: assert property (p_chargeInsideBlank) else $error("charge outside blank");

    property p_chargeNeedsEnable;
        (fastChargeCurrent & ~$past(fastChargeCurrent)
            & ~$past(diagConfigTwo[lfc_pkg::FAST_CHARGE_ENABLE_LSB +: CH])) == '0;
    endproperty
    a_chargeNeedsEnable: assert property (p_chargeNeedsEnable) else $error("charge without enable");

    property p_blankHoldsStatus;
        s_blankRunning ##0 (s_q.rstS2 && !(clearEvent && statusClearMask[0])) |=> $stable(channelStatus[0]);
    endproperty
    a_blankHoldsStatus: assert property (p_blankHoldsStatus) else $error("status moved inside blank");

    property p_filterOnChange;
        (diagOn && cmpNow[1] != s_q.cmpPrev[1]) |=> s_q.filtOn[1] && s_q.filtCnt[1] == FLT_CNT;
    endproperty
    a_filterOnChange: assert property (p_filterOnChange) else $error("filter not started");

    property p_offFaultOnlyWhenOff;
        ((channelStatus[1] == lfc_pkg::LFC_ST_GROUND_SHORT || channelStatus[1] == lfc_pkg::LFC_ST_OPEN_LOAD)
            && $changed(channelStatus[1])) |-> !$past(cmd[1]);
    endproperty
    a_offFaultOnlyWhenOff: assert property (p_offFaultOnlyWhenOff) else $error("off fault while on");

    property p_openLoadOff;
        (!$past(diagConfigTwo[lfc_pkg::OPEN_LOAD_DIAG_ENABLE_LSB + 3]) && $changed(channelStatus[3]))
            |-> channelStatus[3] != lfc_pkg::LFC_ST_OPEN_LOAD;
    endproperty
    a_openLoadOff: assert property (p_openLoadOff) else $error("open load with diagnosis off");

    property p_shortedOnlyWhenOn;
        (channelStatus[0] == lfc_pkg::LFC_ST_SHORTED_LOAD && $changed(channelStatus[0])) |-> $past(cmd[0]);
    endproperty
    a_shortedOnlyWhenOn: assert property (p_shortedOnlyWhenOn) else $error("shorted load while off");

    property p_frameClear;
        (clearEvent && statusClearMask[0] && s_q.rstS2 && !latchNow[0])
            |=> channelStatus[0] == lfc_pkg::LFC_ST_NOT_COMPLETE;
    endproperty
    a_frameClear: assert property (p_frameClear) else $error("status not cleared");
endmodule

// file: lfc_host_model.sv
// Purpose: host and drain-side model facing the fault capture block
// Assumes: the shared fault line has a pull-up to the host supply
// Notes: select and comparator levels change only just after a rising edge
`timescale 1ns/1ns
module lfc_host_model (
    input wire logic core_clk,
    input wire logic faultFlagN,
    input wire logic faultFlagOe,
    output logic serialSelectN,
    output logic frameValid,
    output logic [5:0] statusClearMask,
    output lfc_pkg::lfc_cmp_pins_t [5:0] drainFeedback,
    output logic faultWire
);
    // pull-up wins whenever the block is not pulling, so a released flag reads high
    assign faultWire = faultFlagOe ? faultFlagN : 1'b1;

    // idle host: deselected, every drain well above the open-load reference
    initial
    begin
        serialSelectN = 1'b1;
        frameValid = 1'b0;
        statusClearMask = 6'h00;
        drainFeedback = {6{4'h4}};
    end

    // comparator outputs of one channel
    task automatic setDrain(input int ch, input logic [3:0] v);
        @(posedge core_clk);
        drainFeedback[ch] <= v;
    endtask

    // one select pulse; valid and mask stand across the select rise
    task automatic frame(input logic [5:0] m, input logic v);
        @(posedge core_clk);
        frameValid <= v;
        statusClearMask <= m;
        serialSelectN <= 1'b0;
        repeat (6) @(posedge core_clk);
        serialSelectN <= 1'b1;
        repeat (6) @(posedge core_clk);
        frameValid <= 1'b0;
        statusClearMask <= 6'h00;
    endtask
endmodule

// file: tb_lowside_fault_capture.sv
// Purpose: self-checking bench for the six-channel fault capture block
// Assumes: 20 MHz core clock, timer counts as set in the package
// Notes: waits carry margin for the two-stage input synchronisers
`timescale 1ns/1ns
module tb_lowside_fault_capture;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic masterResetN = 1'b1;
    logic masterDisable = 1'b0;
    logic [5:0] parallelChannelInput = 6'h00;
    logic [5:0] serialGateCommand = 6'h00;
    logic [11:0] diagConfigTwo = 12'hc37;
    logic serialSelectN, frameValid, faultWire, faultFlagN, faultFlagOe;
    logic [5:0] statusClearMask, fastChargeCurrent;
    lfc_pkg::lfc_cmp_pins_t [5:0] drainFeedback;
    lfc_pkg::lfc_status_t [5:0] channelStatus;
    int failures = 0;
    int total_checks = 0;

    always #25 core_clk = ~core_clk;

    lfc_lowside_fault_capture lfc_lowside_fault_capture_inst (.core_clk(core_clk), .rst(rst),
        .masterResetN(masterResetN), .masterDisable(masterDisable), .serialSelectN(serialSelectN),
        .parallelChannelInput(parallelChannelInput), .serialGateCommand(serialGateCommand),
        .drainFeedback(drainFeedback), .diagConfigTwo(diagConfigTwo), .frameValid(frameValid),
        .statusClearMask(statusClearMask), .faultFlagN(faultFlagN), .faultFlagOe(faultFlagOe),
        .fastChargeCurrent(fastChargeCurrent), .channelStatus(channelStatus));

    lfc_host_model lfc_host_model_inst (.core_clk(core_clk), .faultFlagN(faultFlagN),
        .faultFlagOe(faultFlagOe), .serialSelectN(serialSelectN), .frameValid(frameValid),
        .statusClearMask(statusClearMask), .drainFeedback(drainFeedback), .faultWire(faultWire));

    // compare with four-state equality so an unknown never matches
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic st(input int ch, input logic [2:0] e);
        chk({5'h00, channelStatus[ch]}, {5'h00, e});
    endtask

    // step n edges, then sample once the edge updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // watchdog: the sequence needs about 11400 cycles
    initial
    begin
        repeat (40000) @(posedge core_clk);
        failures++;
        stop_test();
    end

    initial
    begin
        // ch1 open load, ch2 ground short, ch3 open load with its diagnosis off
        lfc_host_model_inst.setDrain(1, 4'h0);
        lfc_host_model_inst.setDrain(2, 4'h2);
        lfc_host_model_inst.setDrain(3, 4'h0);
        cyc(16);
        for (int i = 0; i < 6; i++) st(i, 3'h7);
        chk(faultFlagOe, 1'b0);
        @(posedge core_clk) rst <= 1'b0;
        cyc(100);
        chk(fastChargeCurrent[0], 1'b0);
        cyc(1800);
        for (int i = 0; i < 6; i++) st(i, 3'h7);
        chk(faultWire, 1'b1);
        cyc(150);
        st(0, 3'h5);
        st(1, 3'h3);
        st(2, 3'h2);
        st(3, 3'h5);
        chk(faultWire, 1'b0);
        chk(faultFlagN, 1'b0);
        // select releases the flag, deselect brings it back
        fork
            lfc_host_model_inst.frame(6'h00, 1'b1);
            begin
                cyc(6);
                chk(faultWire, 1'b1);
            end
        join
        cyc(4);
        chk(faultWire, 1'b0);
        lfc_host_model_inst.frame(6'h01, 1'b1);
        cyc(2);
        st(0, 3'h7);
        lfc_host_model_inst.frame(6'h02, 1'b0);
        cyc(2);
        st(1, 3'h3);
        // a fault arriving while disabled must not be captured
        @(posedge core_clk) masterDisable <= 1'b1;
        cyc(5);
        chk(faultFlagOe, 1'b0);
        lfc_host_model_inst.setDrain(0, 4'h2);
        cyc(2500);
        st(0, 3'h7);
        @(posedge core_clk) masterDisable <= 1'b0;
        cyc(1900);
        st(0, 3'h7);
        cyc(150);
        st(0, 3'h2);
        // filter: ch1 promoted to ground short, ch2 not demoted to open load
        lfc_host_model_inst.setDrain(1, 4'h2);
        lfc_host_model_inst.setDrain(2, 4'h0);
        cyc(300);
        st(1, 3'h3);
        cyc(150);
        st(1, 3'h2);
        st(2, 3'h2);
        // on state: ch0 shorted load, ch3 low drain is no fault and completes ok
        @(posedge core_clk) parallelChannelInput <= 6'h09;
        lfc_host_model_inst.setDrain(0, 4'hc);
        lfc_host_model_inst.setDrain(3, 4'h2);
        cyc(900);
        st(0, 3'h2);
        cyc(150);
        st(0, 3'h1);
        st(3, 3'h0);
        // fast charge on ch4 and ch5 from turn-off, ch5 stopped at bridge centre
        @(posedge core_clk) serialGateCommand <= 6'h30;
        cyc(1100);
        @(posedge core_clk) serialGateCommand <= 6'h00;
        cyc(10);
        chk({2'h0, fastChargeCurrent}, 8'h30);
        lfc_host_model_inst.setDrain(5, 4'h1);
        cyc(10);
        chk({2'h0, fastChargeCurrent}, 8'h10);
        cyc(2100);
        chk({2'h0, fastChargeCurrent}, 8'h00);
        // master reset forces not-complete and releases the flag
        @(posedge core_clk) masterResetN <= 1'b0;
        cyc(5);
        for (int i = 0; i < 6; i++) st(i, 3'h7);
        chk(faultWire, 1'b1);
        stop_test();
    end
endmodule
